// ### flash_write_port_protect.sv
// write side of a parallel flash host port with lock-down and supply lockout gating
// assumes all host pins are asynchronous to CLOCK and sampled through two flops
`timescale 1ns/1ps
`include "flash_write_port_consts.svh"

// Functional notes
// - capture address and data on write strobe rising edge as the write event.
// - lock guard low enables lock-down; locked-down blocks refuse unlock and stay locked.
// - lock guard high ignores lock-down; program and erase accepted.
// - program supply at lockout level blocks program and erase.
// - core supply at lockout level inhibits all array writes.
// - address width follows density: 22, 23, 24 or 25 bits.
// - dual-die part: address bit 25 high selects top die; match position.
// - data lines are inputs on writes, drive read data on reads.
// - data drivers released when chip select or output enable deasserted.
// - chip select low activates die; high deselects and releases outputs.
module flash_write_port_protect
   import flash_write_port_pkg::*;
#(
   parameter flash_write_port_pkg::density_t DENSITY = flash_write_port_pkg::DENS_512M,
   parameter bit                             DUAL_DIE = 1'b0,
   parameter bit                             TOP_DIE  = 1'b0
)
(
   // clock and reset
   input  wire logic                     CLOCK,
   input  wire logic                     RST,
   input  wire logic                     CLK_EN,
   // host control pins
   input  wire logic                     CE_N,
   input  wire logic                     OE_N,
   input  wire logic                     WE_N,
   input  wire logic                     LOCK_GUARD_N,
   // host address and data pins
   input  wire flash_write_port_pkg::addr_t ADDR,
   input  wire flash_write_port_pkg::word_t DQ_IN,
   output logic [`DATA_W-1:0]            DQ_OUT,
   output logic                          DQ_OE,
   // supply monitors, high while at or below lockout
   input  wire logic                     PROGRAM_SUPPLY_LOCKOUT_LEVEL,
   input  wire logic                     CORE_LOCKOUT_LEVEL,
   // array side
   input  wire flash_write_port_pkg::word_t READ_DATA,
   input  wire logic                     LOCKED_DOWN,
   output logic [`DIE_SEL_BIT:0]         WR_ADDR,
   output logic [`DATA_W-1:0]            WR_DATA,
   output logic                          WR_EVENT,
   output logic                          WR_ALLOWED,
   output logic                          LOCKDOWN_EN
);
   import flash_write_port_pkg::*;

   localparam int AW = (DENSITY == DENS_64M)  ? `ADDR_W_64M  :
                       (DENSITY == DENS_128M) ? `ADDR_W_128M :
                       (DENSITY == DENS_256M) ? `ADDR_W_256M : `ADDR_W_512M;

   // refuse a die pair built from anything but two 256-Mbit halves
   if (DUAL_DIE && DENSITY != DENS_256M)
   begin : bad_die_cfg
      $error("dual-die arrangement needs two 256-Mbit dies");
   end

   typedef struct packed {
      logic [4:0]  ce_s;     // second stage: four control pins plus the program supply monitor
      logic [4:0]  ce_m;
      word_t       dq_m;
      word_t       dq_s;
      addr_t       a_m;
      addr_t       a_s;
      logic        we_prev;
      word_t       dq_out;
      logic        dq_oe;
      addr_t       wr_addr;
      word_t       wr_data;
      logic        wr_event;
      logic        wr_allowed;
      logic        lockdown_en;
   } state_t;

   state_t st_ff;
   state_t nxt_st;

   // mask address to the density width; die bit always cleared here, the caller restores it for dual-die
   function automatic addr_t mask_addr(input addr_t a);
      addr_t m;
      m = '0;
      for (int i = 0; i < AW; i++)
         m[i] = a[i];
      return m;
   endfunction : mask_addr

   logic ce_n_s;
   logic oe_n_s;
   logic we_n_s;
   logic guard_n_s;
   logic vpp_lo_s;
   logic die_hit;

   // second-stage outputs only; first stage feeds nothing else
   assign ce_n_s    = st_ff.ce_s[0];
   assign oe_n_s    = st_ff.ce_s[1];
   assign we_n_s    = st_ff.ce_s[2];
   assign guard_n_s = st_ff.ce_s[3];
   assign vpp_lo_s  = st_ff.ce_s[4];

   assign die_hit = !DUAL_DIE || (st_ff.a_s[`DIE_SEL_BIT] == TOP_DIE);

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.ce_m = {PROGRAM_SUPPLY_LOCKOUT_LEVEL, LOCK_GUARD_N, WE_N, OE_N, CE_N};
      nxt_st.ce_s = st_ff.ce_m;
      nxt_st.dq_m = DQ_IN;
      nxt_st.dq_s = st_ff.dq_m;
      nxt_st.a_m  = ADDR;
      nxt_st.a_s  = st_ff.a_m;
      nxt_st.we_prev  = we_n_s;
      nxt_st.wr_event = 1'b0;
      nxt_st.lockdown_en = !guard_n_s;
      // core monitor is same-domain, so read without sync
      // supply lockouts, guard high overrides lock-down
      nxt_st.wr_allowed = !vpp_lo_s && !CORE_LOCKOUT_LEVEL
                          && (guard_n_s || !LOCKED_DOWN);
      // strobe rising edge with chip selected
      if (!st_ff.we_prev && we_n_s && !ce_n_s && die_hit)
      begin
         nxt_st.wr_addr  = mask_addr(st_ff.a_s);
         if (DUAL_DIE)
            nxt_st.wr_addr[`DIE_SEL_BIT] = st_ff.a_s[`DIE_SEL_BIT];
         nxt_st.wr_data  = st_ff.dq_s;
         // core lockout blocks the event entirely
         nxt_st.wr_event = !CORE_LOCKOUT_LEVEL;
      end
      // drive only on a selected read
      nxt_st.dq_oe  = !ce_n_s && !oe_n_s && we_n_s && die_hit;
      nxt_st.dq_out = nxt_st.dq_oe ? READ_DATA : `WORD_RESET;
   end

   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         st_ff <= '0;
         // pins read as idle, so no false strobe edge after reset
         st_ff.ce_m <= `SYNC_RESET;
         st_ff.ce_s <= `SYNC_RESET;
         st_ff.we_prev <= 1'b1;
      end
      else if (CLK_EN)
         st_ff <= nxt_st;
   end

   assign DQ_OUT      = st_ff.dq_out;
   assign DQ_OE       = st_ff.dq_oe;
   assign WR_ADDR     = st_ff.wr_addr;
   assign WR_DATA     = st_ff.wr_data;
   assign WR_EVENT    = st_ff.wr_event;
   assign WR_ALLOWED  = st_ff.wr_allowed;
   assign LOCKDOWN_EN = st_ff.lockdown_en;

   release_dq_a: assert property (@(posedge CLOCK) disable iff (RST)
      CLK_EN && $past(CLK_EN) && ($past(ce_n_s) || $past(oe_n_s)) |-> !DQ_OE)
      else $error("data drivers on while deselected");

   strobe_event_a: assert property (@(posedge CLOCK) disable iff (RST)
      WR_EVENT && $past(CLK_EN) |-> $past(we_n_s) && !$past(st_ff.we_prev))
      else $error("write event without strobe rise");

   lockdown_guard_a: assert property (@(posedge CLOCK) disable iff (RST)
      $past(CLK_EN) |-> LOCKDOWN_EN == !$past(guard_n_s))
      else $error("lock-down flag disagrees with guard");

   // guard high never blocks on lock
   guard_override_a: assert property (@(posedge CLOCK) disable iff (RST)
      !$past(RST) && $past(CLK_EN) && $past(guard_n_s) && !$past(vpp_lo_s)
      && !$past(CORE_LOCKOUT_LEVEL) |-> WR_ALLOWED)
      else $error("write refused with guard high");

   vpp_lock_a: assert property (@(posedge CLOCK) disable iff (RST)
      $past(CLK_EN) && $past(vpp_lo_s) |-> !WR_ALLOWED)
      else $error("write allowed under program supply lockout");

   core_lock_a: assert property (@(posedge CLOCK) disable iff (RST)
      $past(CLK_EN) && $past(CORE_LOCKOUT_LEVEL) |-> !WR_EVENT && !WR_ALLOWED)
      else $error("write under core lockout");

   addr_width_a: assert property (@(posedge CLOCK) disable iff (RST)
      (WR_ADDR & ~(mask_addr('1) | {DUAL_DIE, {`DIE_SEL_BIT{1'b0}}})) == '0)
      else $error("address above density width");

   die_select_a: assert property (@(posedge CLOCK) disable iff (RST)
      WR_EVENT && DUAL_DIE |-> WR_ADDR[`DIE_SEL_BIT] == TOP_DIE)
      else $error("wrong die accepted write");

   read_drive_a: assert property (@(posedge CLOCK) disable iff (RST)
      DQ_OE |-> !$past(ce_n_s) && $past(we_n_s))
      else $error("drivers on during write or deselect");

   read_data_a: assert property (@(posedge CLOCK) disable iff (RST)
      DQ_OE && $past(CLK_EN) |-> DQ_OUT == $past(READ_DATA))
      else $error("read word differs from array data");

   deselect_event_a: assert property (@(posedge CLOCK) disable iff (RST)
      WR_EVENT && $past(CLK_EN) |-> !$past(ce_n_s))
      else $error("write event while deselected");

   freeze_hold_a: assert property (@(posedge CLOCK) disable iff (RST)
      !$past(CLK_EN) && !$past(RST) |-> $stable(WR_DATA) && $stable(WR_ADDR))
      else $error("captured word moved while enable low");
endmodule : flash_write_port_protect

// ### flash_write_port_consts.svh
// constants for the flash write port: address widths per density, die select bit
// assumes inclusion by the package and the design file only
`ifndef FLASH_WRITE_PORT_CONSTS_SVH
`define FLASH_WRITE_PORT_CONSTS_SVH
`define ADDR_W_64M      22
`define ADDR_W_128M     23
`define ADDR_W_256M     24
`define ADDR_W_512M     25
`define DIE_SEL_BIT     25
`define DATA_W          16
`define WORD_RESET      16'h0000
`define ADDR_RESET      26'h0000000
`define SYNC_RESET      5'h0F
`endif

// ### flash_write_port_pkg.sv
// types shared by the flash write port
// assumes the constants header is on the include path
`include "flash_write_port_consts.svh"
package flash_write_port_pkg;
   typedef enum logic [1:0]
   {
      DENS_64M  = 2'h0,
      DENS_128M = 2'h1,
      DENS_256M = 2'h2,
      DENS_512M = 2'h3
   } density_t;

   typedef logic [`DATA_W-1:0] word_t;
   typedef logic [`DIE_SEL_BIT:0] addr_t;
endpackage : flash_write_port_pkg

// ### flash_host_model.sv
// host memory controller model for the flash port pins
// assumes the bench calls wr and rd from its main sequence
`timescale 1ns/1ps
module flash_host_model
   import flash_write_port_pkg::*;
(
   // clock and read side
   input  wire logic  CLOCK,
   input  wire logic  DQ_OE,
   input  wire word_t DQ_OUT,
   // pins toward the port
   output logic       CE_N = 1'b1,
   output logic       OE_N = 1'b1,
   output logic       WE_N = 1'b1,
   output addr_t      ADDR = '0,
   output word_t      DQ = '0
);
   task automatic wr(input addr_t a, input word_t d, input logic ce);
      @(posedge CLOCK);
      CE_N <= ce;
      OE_N <= 1'b1;
      WE_N <= 1'b0;
      ADDR <= a;
      DQ   <= d;
      repeat (4) @(posedge CLOCK);
      WE_N <= 1'b1;
      repeat (4) @(posedge CLOCK);
      CE_N <= 1'b1;
      // released bus shows no stale word
      DQ   <= ~d;
   endtask : wr

   task automatic rd(output logic oe, output word_t q);
      @(posedge CLOCK);
      CE_N <= 1'b0;
      OE_N <= 1'b0;
      repeat (5) @(posedge CLOCK);
      oe = DQ_OE;
      q = DQ_OUT;
      OE_N <= 1'b1;
      CE_N <= 1'b1;
   endtask : rd
endmodule : flash_host_model

// ### flash_write_port_protect_bench.sv
// self-checking bench for the flash write port
// assumes default 512-Mbit single die build, plus a top die of a dual-die pair
`timescale 1ns/1ps
module flash_write_port_protect_bench;
   import flash_write_port_pkg::*;
   logic  clock = 1'b0, rst = 1'b1, guard_n = 1'b1, prog_lo = 1'b0;
   logic  core_lo = 1'b0, locked = 1'b0, dq_oe, ev, allowed, lock_en;
   logic  ce_n, oe_n, we_n;
   addr_t addr, wr_addr;
   word_t dq, dq_out, wr_data, rdata = 16'h0000;
   int    errors = 0, checks = 0, events = 0, cycles = 0;
   logic  clk_en = 1'b1, top_ev;
   addr_t top_addr;
   int    top_events = 0;

   initial
   begin
      forever #5 clock = ~clock;
   end

   flash_host_model flash_host_model_i (.CLOCK(clock), .DQ_OE(dq_oe), .DQ_OUT(dq_out),
      .CE_N(ce_n), .OE_N(oe_n), .WE_N(we_n), .ADDR(addr), .DQ(dq));

   // top die of a dual-die pair on the same host pins
   if (1)
   begin : top_die
      flash_write_port_protect #(.DENSITY(DENS_256M), .DUAL_DIE(1'b1), .TOP_DIE(1'b1))
         flash_write_port_protect_i (.CLOCK(clock), .RST(rst), .CLK_EN(clk_en),
         .CE_N(ce_n), .OE_N(oe_n), .WE_N(we_n), .LOCK_GUARD_N(guard_n), .ADDR(addr),
         .DQ_IN(dq), .DQ_OUT(), .DQ_OE(), .PROGRAM_SUPPLY_LOCKOUT_LEVEL(prog_lo),
         .CORE_LOCKOUT_LEVEL(core_lo), .READ_DATA(rdata), .LOCKED_DOWN(locked),
         .WR_ADDR(top_addr), .WR_DATA(), .WR_EVENT(top_ev), .WR_ALLOWED(),
         .LOCKDOWN_EN());
   end

   flash_write_port_protect flash_write_port_protect_i (.CLOCK(clock), .RST(rst),
      .CLK_EN(clk_en), .CE_N(ce_n), .OE_N(oe_n), .WE_N(we_n), .LOCK_GUARD_N(guard_n),
      .ADDR(addr), .DQ_IN(dq), .DQ_OUT(dq_out), .DQ_OE(dq_oe),
      .PROGRAM_SUPPLY_LOCKOUT_LEVEL(prog_lo), .CORE_LOCKOUT_LEVEL(core_lo),
      .READ_DATA(rdata), .LOCKED_DOWN(locked), .WR_ADDR(wr_addr), .WR_DATA(wr_data),
      .WR_EVENT(ev), .WR_ALLOWED(allowed), .LOCKDOWN_EN(lock_en));

   always @(posedge clock)
   begin
      events <= events + int'(ev === 1'b1);
      top_events <= top_events + int'(top_ev === 1'b1);
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         errors++;
         end_of_test();
      end
   end

   task automatic check(input logic [25:0] seen, input logic [25:0] exp);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask : check

   task automatic t_write;
      int n;
      n = events;
      flash_host_model_i.wr(26'h3FFFFFF, 16'hA5C3, 1'b0);
      // event counter updates on the edge the strobe task returns, so read it one edge later
      @(posedge clock);
      check(26'(events - n), 26'h1);
      check(wr_data, 16'hA5C3);
      check(wr_addr, 26'h1FFFFFF);
      $display("t_write done");
   endtask : t_write

   task automatic t_refuse;
      int n;
      n = events;
      core_lo <= 1'b1;
      flash_host_model_i.wr(26'h0000123, 16'h1111, 1'b0);
      core_lo <= 1'b0;
      flash_host_model_i.wr(26'h0000456, 16'h2222, 1'b1);
      @(posedge clock);
      check(26'(events - n), 26'h0);
      // a refused write still latches the word; only the event is held back
      check(wr_data, 16'h1111);
      check(wr_addr, 26'h0000123);
      $display("t_refuse done");
   endtask : t_refuse

   task automatic t_freeze;
      int n;
      n = events;
      clk_en <= 1'b0;
      flash_host_model_i.wr(26'h0000789, 16'h7777, 1'b0);
      clk_en <= 1'b1;
      repeat (3) @(posedge clock);
      check(26'(events - n), 26'h0);
      check(wr_data, 16'h1111);
      $display("t_freeze done");
   endtask : t_freeze

   task automatic t_die;
      int n;
      n = top_events;
      flash_host_model_i.wr(26'h3FFFFFF, 16'h3C3C, 1'b0);
      @(posedge clock);
      check(26'(top_events - n), 26'h1);
      check(top_addr, 26'h2FFFFFF);
      flash_host_model_i.wr(26'h1FFFFFF, 16'h4B4B, 1'b0);
      @(posedge clock);
      check(26'(top_events - n), 26'h1);
      check(top_addr, 26'h2FFFFFF);
      check(wr_data, 16'h4B4B);
      $display("t_die done");
   endtask : t_die

   task automatic t_lock;
      locked  <= 1'b1;
      guard_n <= 1'b0;
      repeat (5) @(posedge clock);
      check(lock_en, 1'b1);
      check(allowed, 1'b0);
      guard_n <= 1'b1;
      repeat (5) @(posedge clock);
      check(lock_en, 1'b0);
      check(allowed, 1'b1);
      prog_lo <= 1'b1;
      repeat (5) @(posedge clock);
      check(allowed, 1'b0);
      prog_lo <= 1'b0;
      locked  <= 1'b0;
      $display("t_lock done");
   endtask : t_lock

   task automatic t_read;
      logic  oe;
      word_t q;
      rdata <= 16'h5A3C;
      flash_host_model_i.rd(oe, q);
      check(oe, 1'b1);
      check(q, 16'h5A3C);
      repeat (5) @(posedge clock);
      check(dq_oe, 1'b0);
      $display("t_read done");
   endtask : t_read

   task automatic end_of_test;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   initial
   begin
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      repeat (3) @(posedge clock);
      t_write();
      t_refuse();
      t_freeze();
      t_die();
      t_lock();
      t_read();
      end_of_test();
   end
endmodule : flash_write_port_protect_bench
